// *** pst_pkg.sv ***
// Constants, register map and field layout of the PWM sync trigger control
package pst_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 8;
  localparam int VAL_W = 16;
  localparam int NUM_TRIG = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_SYNC = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SETUP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GATE_BUF = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GATE_ACT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_START = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMP_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CMP_STEP = 8'h04;

  // Field positions
  localparam int SYNC_LSB = 0;
  localparam int SYNC_W = 8;
  localparam int SETUP_SPLIT_BIT = 0;
  localparam int SETUP_ENH_BIT = 1;

  // Reset values
  localparam logic [VAL_W-1:0] RST_VAL = 16'h0000;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // Sync register layout, bit 7 down to bit 0
  typedef struct packed {
    logic software_sync_trigger;
    logic hw_trigger_two_enable;
    logic hw_trigger_one_enable;
    logic hw_trigger_zero_enable;
    logic mask_update_select;
    logic counter_reload_on_sync;
    logic top_load_point_enable;
    logic bottom_load_point_enable;
  } pst_sync_cfg_s;

  localparam pst_sync_cfg_s SYNC_RST = 8'h00;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pst_bus_req_s;

endpackage : pst_pkg

// *** pst_edge_detect.sv ***
// Rising edge detector for the hardware trigger inputs
`timescale 1ns/10ps
`default_nettype none
module pst_edge_detect #(
  parameter int WIDTH = pst_pkg::NUM_TRIG
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Trigger levels and pulses
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } pst_edge_state_s;

  pst_edge_state_s st;
  pst_edge_state_s next_st;

  if (WIDTH < 1) begin : g_width_check
    $error("WIDTH must be at least one");
  end

  always_comb begin
    next_st = st;
    next_st.prev = level;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Low then high between samples
  assign rise = level & ~st.prev;

endmodule : pst_edge_detect
`default_nettype wire

// *** pst_sync_ctrl.sv ***
// PWM synchronization trigger and loading point control
`timescale 1ns/10ps
`default_nettype none
module pst_sync_ctrl #(
  parameter int NUM_CH = pst_pkg::NUM_CH,
  parameter int VAL_W = pst_pkg::VAL_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [pst_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pst_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pst_pkg::DATA_W-1:0] reg_rdata,
  // Hardware trigger inputs
  input wire logic [pst_pkg::NUM_TRIG-1:0] hw_trigger,
  // Counter status and channel enables
  input wire logic counter_at_top,
  input wire logic counter_at_bottom,
  input wire logic [NUM_CH-1:0] channel_enable,
  // Active values
  output logic [VAL_W-1:0] counter_period_limit,
  output logic [VAL_W-1:0] counter_start_value,
  output logic [NUM_CH-1:0][VAL_W-1:0] channel_compare_value,
  output logic [NUM_CH-1:0] channel_output_gate,
  output logic counter_reload
);

  localparam int IDX_W = $clog2(NUM_CH + 1);

  typedef struct packed {
    pst_pkg::pst_sync_cfg_s cfg;
    logic trigger_split_select;
    logic enhanced_sync_select;
    logic sw_pending;
    logic [NUM_CH-1:0] gate_buf;
    logic [NUM_CH-1:0] gate_act;
    logic [VAL_W-1:0] period_buf;
    logic [VAL_W-1:0] period_act;
    logic [VAL_W-1:0] start_buf;
    logic [VAL_W-1:0] start_act;
    logic [NUM_CH-1:0][VAL_W-1:0] cmp_buf;
    logic [NUM_CH-1:0][VAL_W-1:0] cmp_act;
    logic [pst_pkg::DATA_W-1:0] rdata;
    logic reload;
  } pst_ctrl_state_s;

  pst_ctrl_state_s st;
  pst_ctrl_state_s next_st;
  pst_pkg::pst_bus_req_s req;
  logic [pst_pkg::NUM_TRIG-1:0] trig_rise;

  if (NUM_CH < 1 || NUM_CH > 24) begin : g_ch_check
    $error("NUM_CH must lie between 1 and 24");
  end
  if (VAL_W < 1 || VAL_W > pst_pkg::DATA_W) begin : g_val_check
    $error("VAL_W must lie between 1 and DATA_W");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare address decode
  function automatic logic [IDX_W-1:0] cmp_index(input logic [pst_pkg::ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = IDX_W'(NUM_CH);
    for (int i = 0; i < NUM_CH; i++) begin
      if (a == pst_pkg::ADDR_W'(pst_pkg::OFS_CMP_BASE + i * pst_pkg::OFS_CMP_STEP)) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction : cmp_index

  ////////////////////////////////////////////////////////////////////////////
  // Trigger edges
  pst_edge_detect #(
    .WIDTH(pst_pkg::NUM_TRIG)
  ) u_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(hw_trigger),
    .rise(trig_rise)
  );

  assign req = {reg_wr, reg_rd, reg_addr, reg_wdata};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic hw_evt;
    logic load_pt;
    logic any_load_en;
    logic sw_evt;
    logic split;
    logic upd_values;
    logic upd_gate;
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;
    hw_evt = 1'b0;
    load_pt = 1'b0;
    any_load_en = 1'b0;
    sw_evt = 1'b0;
    split = 1'b0;
    upd_values = 1'b0;
    upd_gate = 1'b0;
    widx = cmp_index(req.addr);
    ridx = cmp_index(req.addr);
    next_st = st;

    // Hardware trigger selection
    hw_evt = (trig_rise[2] & st.cfg.hw_trigger_two_enable)
           | (trig_rise[1] & st.cfg.hw_trigger_one_enable)
           | (trig_rise[0] & st.cfg.hw_trigger_zero_enable);

    // Loading points
    load_pt = (st.cfg.top_load_point_enable & counter_at_top)
            | (st.cfg.bottom_load_point_enable & counter_at_bottom);
    any_load_en = st.cfg.top_load_point_enable | st.cfg.bottom_load_point_enable;

    // Software trigger waits for a loading point when one is enabled
    sw_evt = st.sw_pending & (load_pt | ~any_load_en);

    // Split applies only in basic mode
    split = st.trigger_split_select & ~st.enhanced_sync_select;
    upd_values = sw_evt | (hw_evt & ~split);
    upd_gate = hw_evt | (sw_evt & ~split);

    // Synchronized transfer in one cycle; compare values move only for enabled channels
    if (upd_values) begin
      next_st.period_act = st.period_buf;
      next_st.start_act = st.start_buf;
      for (int i = 0; i < NUM_CH; i++) begin
        if (channel_enable[i]) begin
          next_st.cmp_act[i] = st.cmp_buf[i];
        end
      end
    end
    if (!st.cfg.mask_update_select || upd_gate) begin
      next_st.gate_act = st.gate_buf;
    end
    next_st.reload = upd_gate & st.cfg.counter_reload_on_sync & ~st.enhanced_sync_select;
    if (sw_evt) begin
      next_st.sw_pending = 1'b0;
    end

    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        pst_pkg::OFS_SYNC: begin
          next_st.cfg = req.wdata[pst_pkg::SYNC_LSB +: pst_pkg::SYNC_W];
          next_st.cfg.software_sync_trigger = 1'b0;
          if (req.wdata[pst_pkg::SYNC_LSB + pst_pkg::SYNC_W - 1]) begin
            next_st.sw_pending = 1'b1;
          end
        end
        pst_pkg::OFS_SETUP: begin
          next_st.trigger_split_select = req.wdata[pst_pkg::SETUP_SPLIT_BIT];
          next_st.enhanced_sync_select = req.wdata[pst_pkg::SETUP_ENH_BIT];
        end
        pst_pkg::OFS_GATE_BUF: begin
          next_st.gate_buf = req.wdata[NUM_CH-1:0];
        end
        pst_pkg::OFS_PERIOD: begin
          next_st.period_buf = req.wdata[VAL_W-1:0];
        end
        pst_pkg::OFS_START: begin
          next_st.start_buf = req.wdata[VAL_W-1:0];
        end
        default: begin
          if (widx < IDX_W'(NUM_CH)) begin
            next_st.cmp_buf[widx] = req.wdata[VAL_W-1:0];
          end
        end
      endcase
    end

    // Register reads, data stand one cycle
    next_st.rdata = pst_pkg::RD_ZERO;
    if (req.rd) begin
      unique case (req.addr)
        pst_pkg::OFS_SYNC: begin
          next_st.rdata[pst_pkg::SYNC_LSB +: pst_pkg::SYNC_W] = {st.sw_pending, st.cfg[6:0]};
        end
        pst_pkg::OFS_SETUP: begin
          next_st.rdata[pst_pkg::SETUP_SPLIT_BIT] = st.trigger_split_select;
          next_st.rdata[pst_pkg::SETUP_ENH_BIT] = st.enhanced_sync_select;
        end
        pst_pkg::OFS_GATE_BUF: begin
          next_st.rdata[NUM_CH-1:0] = st.gate_buf;
        end
        pst_pkg::OFS_GATE_ACT: begin
          next_st.rdata[NUM_CH-1:0] = st.gate_act;
        end
        pst_pkg::OFS_PERIOD: begin
          next_st.rdata[VAL_W-1:0] = st.period_buf;
        end
        pst_pkg::OFS_START: begin
          next_st.rdata[VAL_W-1:0] = st.start_buf;
        end
        default: begin
          if (ridx < IDX_W'(NUM_CH)) begin
            next_st.rdata[VAL_W-1:0] = st.cmp_buf[ridx];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.cfg <= pst_pkg::SYNC_RST;
      st.period_buf <= pst_pkg::RST_VAL;
      st.period_act <= pst_pkg::RST_VAL;
      st.start_buf <= pst_pkg::RST_VAL;
      st.start_act <= pst_pkg::RST_VAL;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = st.rdata;
  assign counter_period_limit = st.period_act;
  assign counter_start_value = st.start_act;
  assign channel_compare_value = st.cmp_act;
  assign channel_output_gate = st.gate_act;
  assign counter_reload = st.reload;

endmodule : pst_sync_ctrl
`default_nettype wire

// *** pst_pkg_dummy_guard.sv ***
// Empty companion kept out
`default_nettype none
`default_nettype wire

// *** pst_checker.sv ***
// Port checker for the PWM sync trigger control
`timescale 1ns/10ps
`default_nettype none
module pst_checker #(
  parameter int NUM_CH = 8,
  parameter int VAL_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  // Triggers and counter status
  input wire logic [2:0] hw_trigger,
  input wire logic counter_at_top,
  input wire logic counter_at_bottom,
  // Active values
  input wire logic [VAL_W-1:0] counter_period_limit,
  input wire logic [VAL_W-1:0] counter_start_value,
  input wire logic [NUM_CH-1:0][VAL_W-1:0] channel_compare_value,
  input wire logic [NUM_CH-1:0] channel_output_gate,
  input wire logic counter_reload
);
  logic [2:0] hw_q;
  logic w1, w2, e1;
  ////////////////////////////////////////
  // Event history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_q <= 3'h0;
      w1 <= 1'b0;
      w2 <= 1'b0;
      e1 <= 1'b0;
    end else begin
      hw_q <= hw_trigger;
      w1 <= reg_wr;
      w2 <= w1;
      e1 <= (|(hw_trigger & ~hw_q)) | counter_at_top | counter_at_bottom;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_read;
    reg_rd && reg_addr == 8'h00 ##1 1'b1;
  endsequence
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rsv;
    s_read |-> reg_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("upper bits not zero");
  property p_reload_cause;
    counter_reload |-> e1 || w2;
  endproperty
  a_reload_cause: assert property (p_reload_cause) else $error("reload without trigger");
  property p_reload_one;
    counter_reload |=> !counter_reload;
  endproperty
  a_reload_one: assert property (p_reload_one) else $error("reload too long");
  property p_period;
    $changed(counter_period_limit) |-> e1 || w2;
  endproperty
  a_period: assert property (p_period) else $error("period changed without sync");
  property p_start;
    $changed(counter_start_value) |-> e1 || w2;
  endproperty
  a_start: assert property (p_start) else $error("start changed without sync");
  property p_cmp;
    $changed(channel_compare_value) |-> e1 || w2;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare changed without sync");
  property p_gate;
    $changed(channel_output_gate) |-> e1 || w1 || w2;
  endproperty
  a_gate: assert property (p_gate) else $error("gate changed without cause");
endmodule : pst_checker
bind pst_sync_ctrl pst_checker #(.NUM_CH(NUM_CH), .VAL_W(VAL_W)) chk_u (.clk(clk), .reset_n(reset_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .hw_trigger(hw_trigger),
  .counter_at_top(counter_at_top), .counter_at_bottom(counter_at_bottom),
  .counter_period_limit(counter_period_limit), .counter_start_value(counter_start_value),
  .channel_compare_value(channel_compare_value), .channel_output_gate(channel_output_gate),
  .counter_reload(counter_reload));
`default_nettype wire

// *** pst_trig_src.sv ***
// Model of the trigger sources and counter status
`timescale 1ns/10ps
`default_nettype none
module pst_trig_src (
  // Clock
  input wire logic clk,
  // Triggers and counter status
  output logic [2:0] hw_trigger,
  output logic counter_at_top,
  output logic counter_at_bottom
);
  initial begin
    hw_trigger = 3'h0;
    counter_at_top = 1'b0;
    counter_at_bottom = 1'b0;
  end
  ////////////////////////////////////////
  // Level held two cycles
  task automatic pulse(input int k);
    @(posedge clk);
    hw_trigger[k] <= 1'b1;
    repeat (2) @(posedge clk);
    hw_trigger[k] <= 1'b0;
  endtask : pulse
  // One-cycle counter boundary
  task automatic point(input logic top);
    @(posedge clk);
    counter_at_top <= top;
    counter_at_bottom <= !top;
    @(posedge clk);
    counter_at_top <= 1'b0;
    counter_at_bottom <= 1'b0;
  endtask : point
endmodule : pst_trig_src
`default_nettype wire

// *** tb_pwm_sync_trigger_control.sv ***
// Testbench for the PWM sync trigger control
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_sync_trigger_control;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  pst_pkg::pst_bus_req_s req = '0;
  logic [31:0] rdata;
  logic [2:0] hw_trigger;
  logic at_top, at_bot, reload;
  logic [7:0] ch_en = 8'h01;
  logic [15:0] period, start;
  logic [7:0][15:0] cmp;
  logic [7:0] gate;
  int error_cnt = 0;
  int samples_checked = 0;
  int reloads = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  always @(negedge clk) begin
    if (reload === 1'b1) begin
      reloads++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  pst_sync_ctrl dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(req.addr), .reg_wdata(req.wdata),
    .reg_wr(req.wr), .reg_rd(req.rd), .reg_rdata(rdata), .hw_trigger(hw_trigger),
    .counter_at_top(at_top), .counter_at_bottom(at_bot), .channel_enable(ch_en),
    .counter_period_limit(period), .counter_start_value(start), .channel_compare_value(cmp),
    .channel_output_gate(gate), .counter_reload(reload));
  pst_trig_src src_u (.clk(clk), .hw_trigger(hw_trigger), .counter_at_top(at_top),
    .counter_at_bottom(at_bot));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk);
    req <= '0;
    #1 check(rdata, e, m);
  endtask : rd
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  task automatic t_regs;
    rd(8'h00, 32'h0000_0000, "sync reset");
    wr(8'h00, 32'hFFFF_FF7F);
    rd(8'h00, 32'h0000_007F, "upper bits");
    check(period, 32'h0000_0000, "zero trigger");
    rd(8'hFC, 32'h0000_0000, "unmapped");
    wr(8'h00, 32'h0000_0000);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_sw;
    wr(8'h10, 32'h0000_1234);
    wr(8'h14, 32'h0000_0010);
    wr(8'h20, 32'h0000_0AAA);
    wr(8'h24, 32'h0000_0BBB);
    wr(8'h08, 32'h0000_005A);
    tick(2);
    check(gate, 32'h0000_005A, "gate each clock");
    check(period, 32'h0000_0000, "period buffered");
    rd(8'h10, 32'h0000_1234, "period buffer");
    rd(8'h14, 32'h0000_0010, "start buffer");
    rd(8'h24, 32'h0000_0BBB, "compare buffer");
    rd(8'h08, 32'h0000_005A, "gate buffer");
    wr(8'h00, 32'h0000_0084);
    tick(1);
    check(reload, 32'h0000_0001, "reload pulse");
    check({start, period}, 32'h0010_1234, "sw values");
    check(cmp[1:0], 32'h0000_0AAA, "enabled channel");
    rd(8'h00, 32'h0000_0004, "trigger cleared");
    $display("t_sw done");
  endtask : t_sw
  task automatic t_hw;
    logic [7:0] g;
    logic [7:0] eg;
    eg = 8'h5A;
    wr(8'h00, 32'h0000_0008);
    wr(8'h08, 32'h0000_00C3);
    tick(3);
    check(gate, eg, "gate held");
    for (int k = 0; k < 3; k++) begin
      g = 8'h11 << k;
      wr(8'h08, {24'h00_0000, g});
      wr(8'h00, 32'h0000_0008 | (32'h0000_0010 << ((k + 1) % 3)));
      src_u.pulse(k);
      tick(2);
      check(gate, eg, "trigger off");
      wr(8'h00, 32'h0000_0008 | (32'h0000_0010 << k));
      src_u.pulse(k);
      tick(2);
      eg = g;
      check(gate, eg, "trigger on");
    end
    rd(8'h0C, 32'h0000_0044, "active gate");
    $display("t_hw done");
  endtask : t_hw
  task automatic t_split;
    int r;
    r = reloads;
    wr(8'h04, 32'h0000_0001);
    wr(8'h10, 32'h0000_2222);
    wr(8'h08, 32'h0000_000F);
    wr(8'h00, 32'h0000_001C);
    src_u.pulse(0);
    tick(2);
    check({period, 8'h00, gate}, 32'h1234_000F, "hw split");
    check(reloads - r, 32'h0000_0001, "hw reload");
    wr(8'h08, 32'h0000_00F0);
    wr(8'h00, 32'h0000_008C);
    tick(2);
    check({period, 8'h00, gate}, 32'h2222_000F, "sw split");
    check(reloads - r, 32'h0000_0001, "sw no reload");
    wr(8'h04, 32'h0000_0002);
    wr(8'h10, 32'h0000_3333);
    wr(8'h00, 32'h0000_001C);
    src_u.pulse(0);
    tick(2);
    check({period, 8'h00, gate}, 32'h3333_00F0, "enhanced");
    check(reloads - r, 32'h0000_0001, "enhanced reload");
    rd(8'h04, 32'h0000_0002, "setup readback");
    wr(8'h04, 32'h0000_0000);
    $display("t_split done");
  endtask : t_split
  task automatic t_points;
    @(posedge clk);
    ch_en <= 8'h03;
    for (int k = 0; k < 2; k++) begin
      wr(8'h10, 32'h0000_4440 + k);
      wr(8'h00, 32'h0000_0082 - k);
      tick(4);
      check(period, k ? 32'h0000_4440 : 32'h0000_3333, "pending");
      rd(8'h00, 32'h0000_0082 - k, "pending shown");
      src_u.point(k == 0);
      tick(1);
      check(period, 32'h0000_4440 + k, "load point");
    end
    check(cmp[1:0], 32'h0BBB_0AAA, "both channels");
    $display("t_points done");
  endtask : t_points
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_sw();
    t_hw();
    t_split();
    t_points();
    close_out();
  end
endmodule : tb_pwm_sync_trigger_control
`default_nettype wire
